// [hw/rsmt_top.v]
/*
 * Signal-strength measurement, threshold flag and interrupt routing,
 * with the receive configuration registers.
 * Assumes a register master on core_clk and an amplifier-ladder level
 * from the analog chain arriving asynchronously.
 */
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "rsmt_defines.vh"

// Function
// [R1] level taken from 11 amplifier stages of 6 dB plus half-gain taps
// [R2] OOK: sixteen samples per second IF period
// [R3] FSK: sixteen samples per programmed deviation period
// [R4] reported strength averages the last sixteen samples
// [R5] 8-bit value register refreshed on every new sample
// [R6] one value step is 0.5 dB
// [R7] value compared against an 8-bit programmed threshold
// [R8] threshold event sets status bit 2, cleared by writing one
// [R9] routing fields 7:6 and 5:4 steer the event to either pin
// [R10] IF gain field 1:0, 4.5 dB steps, resets to 0 dB
// [R11] sync bit 7 picks polyphase (OOK) or Butterworth (FSK)
// [R12] upper filter nibble sets passive filter bandwidth
// [R13] lower filter nibble sets active filter cut-off
// [R14] polyphase bits 7:4 set centre frequency, default 0011
// [R15] software matches deviation to the transmitter in FSK
// [R16] software sets deviation equal to second IF in OOK
// [R17] receive runs while chip mode field holds 011
// [R18] flag set when average strictly exceeds threshold, sticky
// [R19] pin asserts while flag set and its field selects strength
module rsmt_top (
    input  wire                    core_clk,
    input  wire                    rst_n,
    input  wire [`RSMT_ADDR_W-1:0] reg_addr,
    input  wire [7:0]              reg_wdata,
    input  wire                    reg_write,
    input  wire                    reg_read,
    output reg  [7:0]              reg_rdata,
    input  wire [4:0]              ladder_level,
    output wire                    rx_active,
    output wire [1:0]              if_gain_select,
    output wire [3:0]              passive_filter_bandwidth,
    output wire [3:0]              active_filter_cutoff,
    output wire [3:0]              polyphase_center_freq,
    output wire                    polyphase_filter_enable,
    output wire [7:0]              deviation_value,
    output wire                    interrupt_pin_zero,
    output wire                    interrupt_pin_one
);

    reg  [7:0] general_config_register;
    reg  [7:0] data_modulation_register;
    reg  [7:0] deviation_setting;
    reg  [7:0] channel_filter_control;
    reg  [7:0] polyphase_control_register;
    reg  [7:0] sync_control_register;
    reg  [7:0] fifo_txrx_irq_register;
    reg  [7:0] signal_strength_threshold;
    reg  [7:0] signal_strength_value;
    reg        strength_irq_status;
    reg  [4:0] level_meta;
    reg  [4:0] level_sync;
    reg  [4:0] level_prev;
    reg  [4:0] level_stable;
    reg  [7:0] sample;
    reg  [7:0] next_rdata;
    wire       sample_en;
    wire [7:0] average;
    wire       average_valid;
    wire       wr_gencfg;
    wire       wr_datamod;
    wire       wr_deviation;
    wire       wr_filter;
    wire       wr_polyphase;
    wire       wr_sync;
    wire       wr_route;
    wire       wr_status;
    wire       wr_threshold;
    wire       over_threshold;
    wire       status_clear;
    wire       pin0_selected;
    wire       pin1_selected;

    // ladder tap index in half-dB units, with IF attenuation added back
    function [7:0] rsmt_to_half_db;
        input [4:0] level;
        input [1:0] gain_code;
        reg   [4:0] clipped;
        reg   [7:0] tap_part;
        reg   [7:0] gain_part;
        begin
            clipped   = (level > `RSMT_TAPS) ? `RSMT_TAPS : level;
            tap_part  = {3'h0, clipped} * `RSMT_TAP_STEP;
            gain_part = {6'h00, gain_code} * `RSMT_GAIN_STEP;
            rsmt_to_half_db = tap_part + gain_part;
        end
    endfunction

    function rsmt_hit;
        input [`RSMT_ADDR_W-1:0] addr;
        input [`RSMT_ADDR_W-1:0] ofs;
        begin
            rsmt_hit = (addr == ofs);
        end
    endfunction

    assign wr_gencfg    = reg_write & rsmt_hit(reg_addr, `RSMT_OFS_GENCFG);
    assign wr_datamod   = reg_write & rsmt_hit(reg_addr, `RSMT_OFS_DATAMOD);
    assign wr_deviation = reg_write & rsmt_hit(reg_addr, `RSMT_OFS_DEVIATION);
    assign wr_filter    = reg_write & rsmt_hit(reg_addr, `RSMT_OFS_FILTER);
    assign wr_polyphase = reg_write & rsmt_hit(reg_addr, `RSMT_OFS_POLYPHASE);
    assign wr_sync      = reg_write & rsmt_hit(reg_addr, `RSMT_OFS_SYNC);
    assign wr_route     = reg_write & rsmt_hit(reg_addr, `RSMT_OFS_IRQ_ROUTE);
    assign wr_status    = reg_write & rsmt_hit(reg_addr, `RSMT_OFS_IRQ_STATUS);
    assign wr_threshold = reg_write & rsmt_hit(reg_addr, `RSMT_OFS_THRESHOLD);

    // configuration registers
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            general_config_register    <= `RSMT_RST_GENCFG;
            data_modulation_register   <= `RSMT_RST_DATAMOD;
            deviation_setting          <= `RSMT_RST_DEVIATION;
            channel_filter_control     <= `RSMT_RST_FILTER;
            polyphase_control_register <= `RSMT_RST_POLYPHASE;
            sync_control_register      <= `RSMT_RST_SYNC;
            fifo_txrx_irq_register     <= `RSMT_RST_IRQ_ROUTE;
            signal_strength_threshold  <= `RSMT_RST_THRESHOLD;
        end else begin
            if (wr_gencfg) begin
                general_config_register <= reg_wdata;
            end
            if (wr_datamod) begin
                data_modulation_register <= reg_wdata;
            end
            if (wr_deviation) begin
                deviation_setting <= reg_wdata;
            end
            if (wr_filter) begin
                channel_filter_control <= reg_wdata;
            end
            if (wr_polyphase) begin
                polyphase_control_register <= reg_wdata;
            end
            if (wr_sync) begin
                sync_control_register <= reg_wdata;
            end
            if (wr_route) begin
                fifo_txrx_irq_register <= reg_wdata;
            end
            if (wr_threshold) begin
                signal_strength_threshold <= reg_wdata;
            end
        end
    end

    // [R17] receive mode decode
    assign rx_active = (general_config_register[`RSMT_MODE_HI:`RSMT_MODE_LO] == `RSMT_MODE_RX);

    // [R10] IF gain field
    assign if_gain_select = data_modulation_register[`RSMT_GAIN_HI:`RSMT_GAIN_LO];
    // [R12] passive bandwidth nibble
    assign passive_filter_bandwidth = channel_filter_control[`RSMT_PASV_HI:`RSMT_PASV_LO];
    // [R13] active cut-off nibble
    assign active_filter_cutoff = channel_filter_control[`RSMT_ACTV_HI:`RSMT_ACTV_LO];
    // [R14] polyphase centre field
    assign polyphase_center_freq = polyphase_control_register[`RSMT_POLCF_HI:`RSMT_POLCF_LO];
    // [R11] filter type select
    assign polyphase_filter_enable = sync_control_register[`RSMT_POLEN_BIT];
    assign deviation_value = deviation_setting;

    // ladder level: two-stage synchroniser, then taken once steady on two edges
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_meta   <= 5'h00;
            level_sync   <= 5'h00;
            level_prev   <= 5'h00;
            level_stable <= 5'h00;
        end else begin
            level_meta <= ladder_level;
            level_sync <= level_meta;
            level_prev <= level_sync;
            if (level_sync == level_prev) begin
                level_stable <= level_sync;
            end
        end
    end

    // [R2] [R3] sample rate from the deviation setting in either mode
    rsmt_rate u_rate (
        .core_clk        (core_clk),
        .rst_n           (rst_n),
        .run             (rx_active),
        .deviation_value (deviation_setting),
        .sample_en       (sample_en)
    );

    // [R1] [R6] convert ladder tap to half-dB sample
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sample <= 8'h00;
        end else begin
            sample <= rsmt_to_half_db(level_stable, `RSMT_GAIN_MAX - if_gain_select);
        end
    end

    // [R4] sixteen-sample sliding average
    rsmt_avg u_avg (
        .core_clk      (core_clk),
        .rst_n         (rst_n),
        .clear         (~rx_active),
        .sample_en     (sample_en),
        .sample        (sample),
        .average       (average),
        .average_valid (average_valid)
    );

    // [R5] value register refresh per sample
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            signal_strength_value <= `RSMT_RST_VALUE;
        end else if (average_valid) begin
            signal_strength_value <= average;
        end
    end

    // [R7] strict comparison of the fresh average
    assign over_threshold = average_valid & (average > signal_strength_threshold);
    assign status_clear   = wr_status & reg_wdata[`RSMT_STAT_BIT];

    // [R8] [R18] sticky flag, write one clears, a new event wins
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            strength_irq_status <= 1'b0;
        end else if (over_threshold) begin
            strength_irq_status <= 1'b1;
        end else if (status_clear) begin
            strength_irq_status <= 1'b0;
        end
    end

    // [R9] [R19] route the flag to either pin
    assign pin0_selected = (fifo_txrx_irq_register[`RSMT_SRC0_HI:`RSMT_SRC0_LO] == `RSMT_SRC_STRENGTH);
    assign pin1_selected = (fifo_txrx_irq_register[`RSMT_SRC1_HI:`RSMT_SRC1_LO] == `RSMT_SRC_STRENGTH);
    assign interrupt_pin_zero = strength_irq_status & pin0_selected;
    assign interrupt_pin_one  = strength_irq_status & pin1_selected;

    // read multiplexer, unmapped reads as zero
    always @* begin
        case (reg_addr)
            `RSMT_OFS_GENCFG:     next_rdata = general_config_register;
            `RSMT_OFS_DATAMOD:    next_rdata = data_modulation_register;
            `RSMT_OFS_DEVIATION:  next_rdata = deviation_setting;
            `RSMT_OFS_FILTER:     next_rdata = channel_filter_control;
            `RSMT_OFS_POLYPHASE:  next_rdata = polyphase_control_register;
            `RSMT_OFS_SYNC:       next_rdata = sync_control_register;
            `RSMT_OFS_IRQ_ROUTE:  next_rdata = fifo_txrx_irq_register;
            `RSMT_OFS_IRQ_STATUS: next_rdata = {5'h00, strength_irq_status, 2'h0};
            `RSMT_OFS_THRESHOLD:  next_rdata = signal_strength_threshold;
            `RSMT_OFS_VALUE:      next_rdata = signal_strength_value;
            default:              next_rdata = 8'h00;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // rsmt_top

`default_nettype wire

// [pkg/rsmt_defines.vh]
/*
 * Constants of the signal-strength measurement block: register offsets,
 * reset values, field positions, codes and scale factors.
 * Assumes inclusion by bare name from the hw/ design files.
 */
`ifndef RSMT_DEFINES_VH
`define RSMT_DEFINES_VH

`define RSMT_ADDR_W          4
`define RSMT_DATA_W          8

`define RSMT_OFS_GENCFG      4'h0
`define RSMT_OFS_DATAMOD     4'h1
`define RSMT_OFS_DEVIATION   4'h2
`define RSMT_OFS_FILTER      4'h3
`define RSMT_OFS_POLYPHASE   4'h4
`define RSMT_OFS_SYNC        4'h5
`define RSMT_OFS_IRQ_ROUTE   4'h6
`define RSMT_OFS_IRQ_STATUS  4'h7
`define RSMT_OFS_THRESHOLD   4'h8
`define RSMT_OFS_VALUE       4'h9

`define RSMT_RST_GENCFG      8'h00
`define RSMT_RST_DATAMOD     8'h00
`define RSMT_RST_DEVIATION   8'h03
`define RSMT_RST_FILTER      8'h00
`define RSMT_RST_POLYPHASE   8'h30
`define RSMT_RST_SYNC        8'h00
`define RSMT_RST_IRQ_ROUTE   8'h00
`define RSMT_RST_THRESHOLD   8'h00
`define RSMT_RST_VALUE       8'h00

`define RSMT_MODE_HI         7
`define RSMT_MODE_LO         5
`define RSMT_MODE_RX         3'h3
`define RSMT_GAIN_HI         1
`define RSMT_GAIN_LO         0
`define RSMT_PASV_HI         7
`define RSMT_PASV_LO         4
`define RSMT_ACTV_HI         3
`define RSMT_ACTV_LO         0
`define RSMT_POLCF_HI        7
`define RSMT_POLCF_LO        4
`define RSMT_POLEN_BIT       7
`define RSMT_SRC0_HI         7
`define RSMT_SRC0_LO         6
`define RSMT_SRC1_HI         5
`define RSMT_SRC1_LO         4
`define RSMT_SRC_STRENGTH    2'h3
`define RSMT_STAT_BIT        2

`define RSMT_TAPS            5'h16
`define RSMT_TAP_STEP        8'h06
`define RSMT_GAIN_STEP       8'h09
`define RSMT_GAIN_MAX        2'h3
`define RSMT_WIN_DEPTH       16
`define RSMT_WIN_LOG2        4
`define RSMT_SUM_W           12
`define RSMT_SAMPLES_PER_PER 16
`define RSMT_DIV_W           9

`endif

// [hw/rsmt_rate.v]
/*
 * Sample-rate divider: one-cycle enable, sixteen per deviation period.
 * Assumes core_clk stands in for the reference; deviation is steady or
 * may change at any time (takes effect at the next reload).
 */
`timescale 1ns/10ps
`default_nettype none
`include "rsmt_defines.vh"

module rsmt_rate (
    input  wire       core_clk,
    input  wire       rst_n,
    input  wire       run,
    input  wire [7:0] deviation_value,
    output reg        sample_en
);

    reg  [`RSMT_DIV_W-1:0] count;
    wire [`RSMT_DIV_W-1:0] reload;

    // period of 2*(dev+1) cycles gives 16 samples per deviation period
    assign reload = {deviation_value, 1'b1};

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count     <= {`RSMT_DIV_W{1'b0}};
            sample_en <= 1'b0;
        end else if (!run) begin
            count     <= {`RSMT_DIV_W{1'b0}};
            sample_en <= 1'b0;
        end else if (count == {`RSMT_DIV_W{1'b0}}) begin
            count     <= reload;
            sample_en <= 1'b1;
        end else begin
            count     <= count - {{(`RSMT_DIV_W-1){1'b0}}, 1'b1};
            sample_en <= 1'b0;
        end
    end

endmodule // rsmt_rate

`default_nettype wire

// [hw/rsmt_avg.v]
/*
 * Sliding average over the last sixteen samples.
 * Assumes sample_en is a one-cycle pulse from the same clock; clear
 * empties the window.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rsmt_defines.vh"

module rsmt_avg (
    input  wire       core_clk,
    input  wire       rst_n,
    input  wire       clear,
    input  wire       sample_en,
    input  wire [7:0] sample,
    output reg  [7:0] average,
    output reg        average_valid
);

    reg  [7:0]                window [0:`RSMT_WIN_DEPTH-1];
    reg  [`RSMT_WIN_LOG2-1:0] wr_ptr;
    reg  [`RSMT_SUM_W-1:0]    sum;
    wire [`RSMT_SUM_W-1:0]    next_sum;
    integer                   i;

    assign next_sum = sum + {4'h0, sample} - {4'h0, window[wr_ptr]};

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr        <= {`RSMT_WIN_LOG2{1'b0}};
            sum           <= {`RSMT_SUM_W{1'b0}};
            average       <= 8'h00;
            average_valid <= 1'b0;
            for (i = 0; i < `RSMT_WIN_DEPTH; i = i + 1) begin
                window[i] <= 8'h00;
            end
        end else if (clear) begin
            wr_ptr        <= {`RSMT_WIN_LOG2{1'b0}};
            sum           <= {`RSMT_SUM_W{1'b0}};
            average_valid <= 1'b0;
            for (i = 0; i < `RSMT_WIN_DEPTH; i = i + 1) begin
                window[i] <= 8'h00;
            end
        end else if (sample_en) begin
            window[wr_ptr] <= sample;
            wr_ptr         <= wr_ptr + {{(`RSMT_WIN_LOG2-1){1'b0}}, 1'b1};
            sum            <= next_sum;
            average        <= next_sum[`RSMT_SUM_W-1:`RSMT_WIN_LOG2];
            average_valid  <= 1'b1;
        end else begin
            average_valid  <= 1'b0;
        end
    end

endmodule // rsmt_avg

`default_nettype wire

// [verification/rsmt_properties.sv]
/*
 * Port-level assertions for the signal-strength measurement top.
 * Assumes one clock domain and an asynchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rsmt_defines.vh"
module rsmt_checker (
    input wire logic                    core_clk,
    input wire logic                    rst_n,
    input wire logic [`RSMT_ADDR_W-1:0] reg_addr,
    input wire logic [7:0]              reg_wdata,
    input wire logic                    reg_write,
    input wire logic                    reg_read,
    input wire logic [7:0]              reg_rdata,
    input wire logic [4:0]              ladder_level,
    input wire logic                    rx_active,
    input wire logic [1:0]              if_gain_select,
    input wire logic [3:0]              passive_filter_bandwidth,
    input wire logic [3:0]              active_filter_cutoff,
    input wire logic [3:0]              polyphase_center_freq,
    input wire logic                    polyphase_filter_enable,
    input wire logic [7:0]              deviation_value,
    input wire logic                    interrupt_pin_zero,
    input wire logic                    interrupt_pin_one
);
    logic [7:0] route;
    // shadow of the routing register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            route <= 8'h00;
        else if (reg_write && reg_addr == `RSMT_OFS_IRQ_ROUTE)
            route <= reg_wdata;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    rdata_idle_a: assert property (
        !$past(reg_read) |-> reg_rdata == 8'h00) else $error("read data not idle");
    mode_write_a: assert property (
        reg_write && reg_addr == `RSMT_OFS_GENCFG |=> rx_active == ($past(reg_wdata[7:5]) == 3'h3))
        else $error("receive mode wrong");
    gain_write_a: assert property (
        reg_write && reg_addr == `RSMT_OFS_DATAMOD |=> if_gain_select == $past(reg_wdata[1:0]))
        else $error("gain field wrong");
    filter_write_a: assert property (
        reg_write && reg_addr == `RSMT_OFS_FILTER
        |=> {passive_filter_bandwidth, active_filter_cutoff} == $past(reg_wdata)) else $error("filter fields wrong");
    poly_write_a: assert property (
        reg_write && reg_addr == `RSMT_OFS_POLYPHASE |=> polyphase_center_freq == $past(reg_wdata[7:4]))
        else $error("centre field wrong");
    sync_write_a: assert property (
        reg_write && reg_addr == `RSMT_OFS_SYNC |=> polyphase_filter_enable == $past(reg_wdata[7]))
        else $error("filter select wrong");
    dev_readback_a: assert property (
        reg_read && reg_addr == `RSMT_OFS_DEVIATION |=> reg_rdata == deviation_value)
        else $error("deviation readback wrong");
    pin0_route_a: assert property (
        interrupt_pin_zero |-> route[7:6] == 2'h3) else $error("pin zero not routed");
    pin1_route_a: assert property (
        interrupt_pin_one |-> route[5:4] == 2'h3) else $error("pin one not routed");
    pins_agree_a: assert property (
        interrupt_pin_zero && route[5:4] == 2'h3 |-> interrupt_pin_one) else $error("pins disagree");
    pin_sticky_a: assert property (
        $fell(interrupt_pin_zero) |-> $past(reg_write) && ($past(reg_addr) == `RSMT_OFS_IRQ_ROUTE
        || $past(reg_addr) == `RSMT_OFS_IRQ_STATUS && $past(reg_wdata[2]))) else $error("flag not sticky");
    pin0_c: cover property (interrupt_pin_zero);
    pin1_c: cover property (interrupt_pin_one);
    rx_c: cover property (rx_active ##1 !rx_active);
endmodule // rsmt_checker
`default_nettype wire

// [verification/rsmt_ladder_model.sv]
/*
 * Amplifier-ladder model: reports the tap index of the analog chain.
 * Assumes the bench sets the wanted tap; the level moves with no clock.
 */
`timescale 1ns/10ps
`default_nettype none
module rsmt_ladder_model (
    input  wire logic [4:0] target_tap,
    output var  logic [4:0] ladder_level
);
    initial ladder_level = 5'h00;
    // eleven 6 dB stages plus half-gain taps
    always @(target_tap)
        ladder_level <= #7 target_tap;
endmodule // rsmt_ladder_model
`default_nettype wire

// [verification/test_rssi_measure_threshold_irq.sv]
/*
 * Self-checking bench for the signal-strength measurement top.
 * Assumes the design files and rsmt_defines.vh are on the include path.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rsmt_defines.vh"
module test_rssi_measure_threshold_irq;
    logic       core_clk = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, v;
    logic [4:0] target_tap = 5'h00;
    wire  [7:0] reg_rdata, deviation_value;
    wire  [4:0] ladder_level;
    wire  [3:0] pbw, acut, pcf;
    wire  [1:0] gain;
    wire        rx_active, pen, pin0, pin1;
    int         n_errors = 0, checks_done = 0, i, k;
    logic [7:0] rst_tab [0:10] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [4:0] lvl [0:4] = '{5'h16, 5'h16, 5'h1e, 5'h05, 5'h00};
    logic [7:0] gsel [0:4] = '{8'h00, 8'h00, 8'h03, 8'h03, 8'h03};
    logic [7:0] thr [0:4] = '{8'h9e, 8'h9f, 8'h64, 8'h00, 8'h00};
    logic [7:0] expv [0:4] = '{8'h9f, 8'h9f, 8'h84, 8'h1e, 8'h00};
    always #25 core_clk = ~core_clk;
    rsmt_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .ladder_level(ladder_level),
        .rx_active(rx_active), .if_gain_select(gain), .passive_filter_bandwidth(pbw),
        .active_filter_cutoff(acut), .polyphase_center_freq(pcf), .polyphase_filter_enable(pen),
        .deviation_value(deviation_value), .interrupt_pin_zero(pin0), .interrupt_pin_one(pin1));
    rsmt_ladder_model model_u (.target_tap(target_tap), .ladder_level(ladder_level));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_write <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_read <= 1'b1; reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task results;
        $display("errors %0d, checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        results;
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 11; i++) begin
            rd(i[3:0], v); chk(v, rst_tab[i]);
        end
        for (i = 0; i < 9; i++)
            if (i != 7) wr(i[3:0], 8'h90 ^ {i[3:0], i[3:0]});
        wr(`RSMT_OFS_VALUE, 8'hff);
        wr(`RSMT_OFS_IRQ_STATUS, 8'hff);
        for (i = 0; i < 10; i++) begin
            rd(i[3:0], v); chk(v, (i == 7 || i == 9) ? 8'h00 : 8'h90 ^ {i[3:0], i[3:0]});
        end
        chk({6'h0, gain}, 8'h01);
        chk({pbw, acut}, 8'ha3);
        chk({pcf, 3'h0, pen}, 8'hd1);
        chk(deviation_value, 8'hb2);
        chk({pin0, pin1, rx_active}, 8'h00);
        for (i = 0; i < 5; i++) begin
            wr(`RSMT_OFS_GENCFG, 8'h00);
            wr(`RSMT_OFS_IRQ_STATUS, 8'h04);
            wr(`RSMT_OFS_DATAMOD, gsel[i]);
            wr(`RSMT_OFS_DEVIATION, 8'h01);
            wr(`RSMT_OFS_THRESHOLD, thr[i]);
            wr(`RSMT_OFS_IRQ_ROUTE, 8'hc0);
            target_tap <= lvl[i];
            repeat (4) @(posedge core_clk);
            wr(`RSMT_OFS_GENCFG, 8'h60);
            #1 chk({7'h0, rx_active}, 8'h01);
            v = 8'hxx;
            for (k = 0; k < 60 && v !== expv[i]; k++)
                rd(`RSMT_OFS_VALUE, v);
            chk(v, expv[i]);
            rd(`RSMT_OFS_IRQ_STATUS, v); chk(v, (i < 4 && i != 1) ? 8'h04 : 8'h00);
            chk({pin0, pin1}, (i < 4 && i != 1) ? 8'h02 : 8'h00);
        end
        wr(`RSMT_OFS_THRESHOLD, 8'h00);
        target_tap <= 5'h16;
        wr(`RSMT_OFS_IRQ_ROUTE, 8'hf0);
        repeat (100) @(posedge core_clk);
        chk({pin0, pin1}, 8'h03);
        wr(`RSMT_OFS_GENCFG, 8'h00);
        rd(`RSMT_OFS_VALUE, v); chk(v, 8'h84);
        wr(`RSMT_OFS_IRQ_STATUS, 8'hfb);
        chk({pin0, pin1}, 8'h03);
        wr(`RSMT_OFS_IRQ_STATUS, 8'h04);
        rd(`RSMT_OFS_IRQ_STATUS, v); chk(v, 8'h00);
        chk({pin0, pin1}, 8'h00);
        results;
    end
endmodule // test_rssi_measure_threshold_irq
bind rsmt_top rsmt_checker chk_u (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .ladder_level(ladder_level), .rx_active(rx_active), .if_gain_select(if_gain_select),
    .passive_filter_bandwidth(passive_filter_bandwidth), .active_filter_cutoff(active_filter_cutoff),
    .polyphase_center_freq(polyphase_center_freq), .polyphase_filter_enable(polyphase_filter_enable),
    .deviation_value(deviation_value), .interrupt_pin_zero(interrupt_pin_zero),
    .interrupt_pin_one(interrupt_pin_one));
`default_nettype wire
